// ===== design/cpp_pkg.sv
// constants and types for the copper port power and inline-power detect block
package cpp_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned MS_PER_S = 1000;
	// register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_IRQ = 12'h008;
	localparam logic [11:0] OFF_PINEN = 12'h00c;
	// control field positions
	localparam int unsigned CB_ANEG = 0;
	localparam int unsigned CB_PWRDN = 1;
	localparam int unsigned CB_PMEN = 2;
	localparam int unsigned CB_DETEN = 3;
	localparam int unsigned CB_LTO = 4;
	localparam int unsigned CB_SLEEP = 6;
	localparam int unsigned CB_WAKE = 8;
	localparam int unsigned CTRL_W = 10;
	localparam logic [9:0] CTRL_RST = 10'h041;
	// status field positions
	localparam int unsigned SB_DET = 0;
	localparam int unsigned SB_LINK = 2;
	localparam int unsigned SB_PM = 3;
	localparam int unsigned SB_OFF = 5;
	// detection status codes
	localparam logic [1:0] DET_SEARCHING = 2'h0;
	localparam logic [1:0] DET_NEEDS_POWER = 2'h1;
	localparam logic [1:0] DET_NONE = 2'h2;
	// times in ms
	localparam logic [15:0] DETECT_MS = 16'd100;
	localparam logic [15:0] RAND_LOW_MS = 16'd80;
	localparam logic [15:0] RAND_SPAN_MS = 16'd141;
	localparam logic [3:0][15:0] SLEEP_MS = {16'd4000, 16'd3000, 16'd2000, 16'd1000};
	localparam logic [3:0][15:0] WAKE_MS = {16'd2000, 16'd800, 16'd400, 16'd160};
	localparam logic [3:0][15:0] LTO_MS = {16'd4000, 16'd3000, 16'd2000, 16'd1000};
	localparam logic [1:0] WAKE_BURSTS = 2'd3;
	localparam logic [15:0] LFSR_SEED_RST = 16'hace1;
	typedef enum logic [1:0] {DetOff, DetSearch, DetFound, DetAneg} cpp_det_t;
	typedef enum logic [1:0] {PmLow, PmWake, PmNormal} cpp_pm_t;
endpackage

// ===== design/cpp_port.sv
// per-port power management and inline-power detect with apb registers
// What this block does
// - detection enable bit starts loopback probing when aneg bit is also set
// - status reads 00 while searching
// - looped-back pulses set status 01
// - detection sets interrupt flag, read clears
// - no loopback within detect time gives 10
// - at 10 start auto-negotiation, report link
// - link failure clears link, resumes detection
// - power-down bit independent of power management
// - power management enabled by its bit anytime
// - cycle low power and wake until energy
// - signal energy enters normal state
// - link loss returns low after timeout
// - reset loads low power state; pm bit resets clear, so normal on first clock
// - forced speed: stay normal once energy seen
// - aneg off in normal: no return low
// - low states keep management and interrupt alive
// - sleep dwell from field, randomized -80/+60 ms
// - wake sends up to three alternating bursts
// - no energy by end of wake: return to low power
`timescale 1ns/1ps
`default_nettype none
module cpp_port
	import cpp_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = cpp_pkg::CLK_HZ / cpp_pkg::MS_PER_S,
	parameter logic [15:0] LFSR_SEED = cpp_pkg::LFSR_SEED_RST
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic flpLoopbackIn,
	input wire logic signalEnergyIn,
	input wire logic linkGoodIn,
	output logic flpProbeEn,
	output logic autonegRun,
	output logic flpBurstA,
	output logic flpBurstB,
	output logic majorBlocksOff,
	output logic management_interrupt_pin_o,
	output logic management_interrupt_pin_oe
);
	import cpp_pkg::*;

	logic [2:0] syncA_q;
	logic [2:0] syncB_q;
	logic loopSeen;
	logic energy;
	logic linkGood;
	logic [CTRL_W-1:0] ctrl_q;
	logic pinEn_q;
	logic irq_q;
	logic linkStat_q;
	logic [1:0] detStat_q;
	cpp_det_t det_q;
	cpp_pm_t pm_q;
	logic [31:0] msCnt_q;
	logic msTick;
	logic [15:0] detCnt_q;
	logic [15:0] pmCnt_q;
	logic [15:0] pmLimit_q;
	logic [15:0] gapCnt_q;
	logic [1:0] burstCnt_q;
	logic [15:0] lfsr_q;
	logic [15:0] randOff;
	logic [15:0] sleepDwell;
	logic [15:0] wakeGap;
	logic rdDone;
	logic wrDone;
	logic setup;
	logic [31:0] rdData;
	logic mapped;
	logic anegOn;
	logic pmOn;
	logic detOn;

	assign anegOn = ctrl_q[CB_ANEG];
	assign pmOn = ctrl_q[CB_PMEN];
	assign detOn = ctrl_q[CB_DETEN];

	// cable-side inputs through two flops
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			syncA_q <= 3'h0;
			syncB_q <= 3'h0;
		end
		else
		begin
			syncA_q <= {linkGoodIn, signalEnergyIn, flpLoopbackIn};
			syncB_q <= syncA_q;
		end
	end
	assign loopSeen = syncB_q[0];
	assign energy = syncB_q[1];
	assign linkGood = syncB_q[2];

	// apb slave, one wait state
	assign setup = psel && penable && !pready;
	assign rdDone = psel && penable && pready && !pwrite;
	assign wrDone = psel && penable && pready && pwrite;
	always_comb
	begin
		rdData = 32'h0;
		mapped = 1'b1;
		case (paddr)
			OFF_CTRL: rdData[CTRL_W-1:0] = ctrl_q;
			OFF_STATUS:
			begin
				rdData[SB_DET+:2] = detStat_q;
				rdData[SB_LINK] = linkStat_q;
				rdData[SB_PM+:2] = pm_q;
				rdData[SB_OFF] = majorBlocksOff;
			end
			OFF_IRQ: rdData[0] = irq_q;
			OFF_PINEN: rdData[0] = pinEn_q;
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite)
				prdata <= rdData;
		end
	end

	// control registers, writable anytime
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			ctrl_q <= CTRL_RST;
			pinEn_q <= 1'b0;
		end
		else if (wrDone)
		begin
			if (paddr == OFF_CTRL)
				ctrl_q <= pwdata[CTRL_W-1:0];
			if (paddr == OFF_PINEN)
				pinEn_q <= pwdata[0];
		end
	end

	// detection flag, set wins over read clear
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			irq_q <= 1'b0;
		else if (det_q == DetSearch && loopSeen)
			irq_q <= 1'b1;
		else if (rdDone && paddr == OFF_IRQ && prdata[0])
			irq_q <= 1'b0;
	end

	// open-drain active-low interrupt, alive in every power state
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			management_interrupt_pin_o <= 1'b0;
			management_interrupt_pin_oe <= 1'b0;
		end
		else
		begin
			management_interrupt_pin_o <= 1'b0;
			management_interrupt_pin_oe <= irq_q && pinEn_q;
		end
	end

	// millisecond tick
	always_ff @(posedge ref_clk)
	begin
		if (srst || msTick)
			msCnt_q <= 32'h0;
		else
			msCnt_q <= msCnt_q + 32'h1;
	end
	assign msTick = (msCnt_q == 32'(CYC_PER_MS - 1));

	// free-running random source
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			lfsr_q <= LFSR_SEED;
		else
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
	end
	assign randOff = {8'h0, lfsr_q[7:0]} % RAND_SPAN_MS;
	assign sleepDwell = SLEEP_MS[ctrl_q[CB_SLEEP+:2]] + randOff - RAND_LOW_MS;
	assign wakeGap = WAKE_MS[ctrl_q[CB_WAKE+:2]] / 16'(WAKE_BURSTS);

	// inline-power detection sequence
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			det_q <= DetOff;
			detStat_q <= DET_SEARCHING;
			detCnt_q <= 16'h0;
		end
		else
		begin
			case (det_q)
				DetOff:
				begin
					detCnt_q <= 16'h0;
					if (detOn)
					begin
						det_q <= DetSearch;
						detStat_q <= DET_SEARCHING;
					end
				end
				DetSearch:
				begin
					if (!detOn)
						det_q <= DetOff;
					else if (loopSeen)
					begin
						det_q <= DetFound;
						detStat_q <= DET_NEEDS_POWER;
					end
					else if (msTick && detCnt_q == DETECT_MS - 16'h1)
					begin
						det_q <= DetAneg;
						detStat_q <= DET_NONE;
					end
					else if (msTick)
						detCnt_q <= detCnt_q + 16'h1;
				end
				DetFound:
				begin
					// partner being powered; hand over to negotiation at timeout
					if (!detOn)
						det_q <= DetOff;
					else if (msTick && detCnt_q >= DETECT_MS - 16'h1)
					begin
						det_q <= DetAneg;
						detStat_q <= DET_NONE;
					end
					else if (msTick)
						detCnt_q <= detCnt_q + 16'h1;
				end
				DetAneg:
				begin
					detCnt_q <= 16'h0;
					if (!detOn)
						det_q <= DetOff;
					else if (linkStat_q && !linkGood)
					begin
						det_q <= DetSearch;
						detStat_q <= DET_SEARCHING;
					end
				end
				default: det_q <= DetOff;
			endcase
		end
	end

	// link status and negotiation control
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			linkStat_q <= 1'b0;
			autonegRun <= 1'b0;
			flpProbeEn <= 1'b0;
		end
		else
		begin
			flpProbeEn <= det_q == DetSearch && detOn && anegOn;
			if (detOn)
			begin
				autonegRun <= det_q == DetAneg && anegOn;
				linkStat_q <= det_q == DetAneg && linkGood;
			end
			else
			begin
				autonegRun <= anegOn;
				linkStat_q <= linkGood;
			end
		end
	end

	// power management state machine
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pm_q <= PmLow;
			pmCnt_q <= 16'h0;
			pmLimit_q <= SLEEP_MS[CTRL_RST[CB_SLEEP+:2]];
			gapCnt_q <= 16'h0;
			burstCnt_q <= 2'h0;
			flpBurstA <= 1'b0;
			flpBurstB <= 1'b0;
		end
		else
		begin
			flpBurstA <= 1'b0;
			flpBurstB <= 1'b0;
			if (!pmOn)
			begin
				pm_q <= PmNormal;
				pmCnt_q <= 16'h0;
			end
			else
			begin
				case (pm_q)
					PmLow:
					begin
						if (energy)
						begin
							pm_q <= PmNormal;
							pmCnt_q <= 16'h0;
						end
						else if (msTick && pmCnt_q >= pmLimit_q)
						begin
							pm_q <= PmWake;
							pmCnt_q <= 16'h0;
							gapCnt_q <= 16'h0;
							burstCnt_q <= 2'h1;
							flpBurstA <= 1'b1;
						end
						else if (msTick)
							pmCnt_q <= pmCnt_q + 16'h1;
					end
					PmWake:
					begin
						if (energy)
						begin
							pm_q <= PmNormal;
							pmCnt_q <= 16'h0;
						end
						else if (msTick && pmCnt_q >= WAKE_MS[ctrl_q[CB_WAKE+:2]] - 16'h1)
						begin
							pm_q <= PmLow;
							pmCnt_q <= 16'h0;
							pmLimit_q <= sleepDwell;
						end
						else if (msTick)
						begin
							pmCnt_q <= pmCnt_q + 16'h1;
							if (gapCnt_q >= wakeGap - 16'h1 && burstCnt_q < WAKE_BURSTS)
							begin
								gapCnt_q <= 16'h0;
								burstCnt_q <= burstCnt_q + 2'h1;
								flpBurstA <= !burstCnt_q[0];
								flpBurstB <= burstCnt_q[0];
							end
							else
								gapCnt_q <= gapCnt_q + 16'h1;
						end
					end
					PmNormal:
					begin
						if (!anegOn || linkStat_q)
							pmCnt_q <= 16'h0;
						else if (msTick && pmCnt_q >= LTO_MS[ctrl_q[CB_LTO+:2]] - 16'h1)
						begin
							pm_q <= PmLow;
							pmCnt_q <= 16'h0;
							pmLimit_q <= sleepDwell;
						end
						else if (msTick)
							pmCnt_q <= pmCnt_q + 16'h1;
					end
					default: pm_q <= PmLow;
				endcase
			end
		end
	end

	// power-down bit and low states gate major blocks
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			majorBlocksOff <= 1'b1;
		else
			majorBlocksOff <= ctrl_q[CB_PWRDN] || (pmOn && pm_q != PmNormal);
	end
endmodule
`default_nettype wire

// ===== test/cpp_link_model.sv
// cable-side link partner model
`timescale 1ns/1ps
`default_nettype none
module cpp_link_model #(
	parameter int LAG = 5
)
(
	input wire logic ref_clk,
	input wire logic flpProbeEn,
	input wire logic autonegRun,
	input wire logic poweredDown,
	input wire logic energyOn,
	input wire logic linkOn,
	output logic flpLoopbackIn,
	output logic signalEnergyIn,
	output logic linkGoodIn
);
	logic [7:0] lagQ = '0;
	// unpowered partner loops probe pulses back, slowly
	always_ff @(posedge ref_clk)
	begin
		lagQ <= {lagQ[6:0], flpProbeEn && poweredDown};
	end
	assign flpLoopbackIn = lagQ[LAG];
	assign signalEnergyIn = energyOn;
	assign linkGoodIn = linkOn && autonegRun;
endmodule
`default_nettype wire

// ===== test/cpp_port_asserts.sv
// pin-level assertions for cpp_port
`timescale 1ns/1ps
`default_nettype none
module cpp_port_asserts (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic flpLoopbackIn,
	input wire logic signalEnergyIn,
	input wire logic flpProbeEn,
	input wire logic autonegRun,
	input wire logic flpBurstA,
	input wire logic flpBurstB,
	input wire logic majorBlocksOff,
	input wire logic management_interrupt_pin_o
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	chk_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("apb access not answered");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_burst_excl: assert property (!(flpBurstA && flpBurstB))
		else $error("bursts on both pairs");
	chk_burst_pulse: assert property (flpBurstA || flpBurstB |=> !(flpBurstA || flpBurstB))
		else $error("burst longer than one cycle");
	chk_probe_aneg: assert property (!(flpProbeEn && autonegRun))
		else $error("probe and autoneg together");
	chk_loop_found: assert property (flpProbeEn ##0 flpLoopbackIn [*5] |=> ##[0:3] !flpProbeEn)
		else $error("probe kept after loopback");
	chk_energy_wake: assert property ($rose(signalEnergyIn) ##0 signalEnergyIn [*8] |-> !majorBlocksOff)
		else $error("energy did not wake blocks");
	chk_pin_level: assert property (management_interrupt_pin_o == 1'b0)
		else $error("interrupt pin driven high");
endmodule
bind cpp_port cpp_port_asserts cpp_port_asserts_i (.ref_clk, .srst, .psel, .penable, .pready,
	.flpLoopbackIn, .signalEnergyIn, .flpProbeEn, .autonegRun, .flpBurstA, .flpBurstB,
	.majorBlocksOff, .management_interrupt_pin_o);
`default_nettype wire

// ===== test/tb_top.sv
// testbench for cpp_port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cpp_pkg::*;
	logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pd = 0, en = 0, lk = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err, flpLoopbackIn, signalEnergyIn, linkGoodIn, flpProbeEn;
	logic autonegRun, flpBurstA, flpBurstB, majorBlocksOff;
	logic management_interrupt_pin_o, management_interrupt_pin_oe;
	int errors = 0, n_checks = 0;
	cpp_port #(.CYC_PER_MS(4), .LFSR_SEED(16'h1357)) cpp_port_i (.ref_clk, .srst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flpLoopbackIn,
		.signalEnergyIn, .linkGoodIn, .flpProbeEn, .autonegRun, .flpBurstA, .flpBurstB,
		.majorBlocksOff, .management_interrupt_pin_o, .management_interrupt_pin_oe);
	cpp_link_model cpp_link_model_i (.ref_clk, .flpProbeEn, .autonegRun, .poweredDown(pd),
		.energyOn(en), .linkOn(lk), .flpLoopbackIn, .signalEnergyIn, .linkGoodIn);
	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic end_sim();
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic hang();
		errors++;
		end_sim();
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && i < 20)
		begin
			@(posedge ref_clk);
			i++;
		end
		if (pready !== 1'b1)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitSt(input logic [31:0] m, input logic [31:0] v);
		int i;
		i = 0;
		apb(0, OFF_STATUS, 32'h0);
		while ((rd & m) !== v && i < 3000)
		begin
			apb(0, OFF_STATUS, 32'h0);
			i++;
		end
		if ((rd & m) !== v)
			hang();
	endtask
	task automatic s_regs();
		apb(0, OFF_CTRL, 32'h0);
		chk("ctrl reset", rd, 32'h41);
		apb(1, OFF_CTRL, 32'h43);
		apb(0, OFF_CTRL, 32'h0);
		chk("pwrdn bit", rd, 32'h43);
		apb(0, OFF_STATUS, 32'h0);
		chk("pm state", 32'(rd[5:3]), 32'h6);
		chk("blocks off", 32'(majorBlocksOff), 32'h1);
		apb(1, 12'h010, 32'h1);
		chk("unmapped err", 32'(err), 32'h1);
		apb(0, 12'h010, 32'h0);
		chk("unmapped data", rd, 32'h0);
		apb(1, OFF_CTRL, 32'h41);
	endtask
	task automatic s_det_none();
		apb(1, OFF_CTRL, 32'h49);
		repeat (300) @(negedge ref_clk);
		apb(0, OFF_STATUS, 32'h0);
		chk("det search", 32'(rd[1:0]), 32'(DET_SEARCHING));
		chk("probe on", 32'(flpProbeEn), 32'h1);
		waitSt(32'h3, 32'(DET_NONE));
		chk("probe off", 32'(flpProbeEn), 32'h0);
		chk("aneg run", 32'(autonegRun), 32'h1);
		lk <= 1;
		waitSt(32'h4, 32'h4);
		lk <= 0;
		waitSt(32'h7, 32'(DET_SEARCHING));
	endtask
	task automatic s_det_found();
		pd <= 1;
		waitSt(32'h3, 32'(DET_NEEDS_POWER));
		apb(1, OFF_PINEN, 32'h1);
		repeat (2) @(negedge ref_clk);
		chk("pin on", 32'(management_interrupt_pin_oe), 32'h1);
		apb(0, OFF_IRQ, 32'h0);
		chk("irq flag", rd, 32'h1);
		apb(0, OFF_IRQ, 32'h0);
		chk("irq clear", rd, 32'h0);
		repeat (2) @(negedge ref_clk);
		chk("pin off", 32'(management_interrupt_pin_oe), 32'h0);
		pd <= 0;
		waitSt(32'h3, 32'(DET_NONE));
		apb(1, OFF_CTRL, 32'h41);
	endtask
	task automatic s_pm();
		int c;
		int nb;
		logic [2:0] pat;
		nb = 0;
		pat = '0;
		apb(1, OFF_CTRL, 32'h45);
		apb(0, OFF_STATUS, 32'h0);
		chk("pm enabled", 32'(rd[5:3]), 32'h2);
		waitSt(32'h18, 32'h0);
		chk("low state", 32'(rd[5:3]), 32'h4);
		for (c = 0; c < 12000 && nb < 3; c++)
		begin
			@(negedge ref_clk);
			if (flpBurstA || flpBurstB)
			begin
				if (nb == 0)
					chk("sleep len", 32'(c > 7600 && c < 8300), 32'h1);
				nb++;
				pat = {pat[1:0], flpBurstB};
			end
		end
		chk("bursts", 32'(pat), 32'h2);
		apb(0, OFF_STATUS, 32'h0);
		chk("wake state", 32'(rd[4:3]), 32'h1);
		repeat (700) @(negedge ref_clk);
		apb(0, OFF_STATUS, 32'h0);
		chk("back low", 32'(rd[4:3]), 32'h0);
		en <= 1;
		repeat (10) @(posedge ref_clk);
		en <= 0;
		apb(0, OFF_STATUS, 32'h0);
		chk("normal", 32'(rd[5:3]), 32'h2);
		repeat (3700) @(negedge ref_clk);
		apb(0, OFF_STATUS, 32'h0);
		chk("lto wait", 32'(rd[4:3]), 32'h2);
		repeat (400) @(negedge ref_clk);
		apb(0, OFF_STATUS, 32'h0);
		chk("lto low", 32'(rd[4:3]), 32'h0);
		apb(1, OFF_CTRL, 32'h44);
		en <= 1;
		repeat (10) @(posedge ref_clk);
		en <= 0;
		repeat (4500) @(negedge ref_clk);
		apb(0, OFF_STATUS, 32'h0);
		chk("stay normal", 32'(rd[4:3]), 32'h2);
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk);
		chk("reset blocks off", 32'(majorBlocksOff), 32'h1);
		srst <= 0;
		s_regs();
		s_det_none();
		s_det_found();
		s_pm();
		end_sim();
	end
endmodule
`default_nettype wire
